// file: rtl/otg_ctrl_pkg.sv
// Constants for the OTG role, session and endpoint FIFO sizing block.
// Assumes an APB master with 32-bit data and a single 40 MHz clock.
//
// Contract
// - The VBUS level is reported as a two-bit band code 0, 1h, 2h or 3h by rising threshold.
// - A read-only host role flag is set while the controller acts as USB host.
// - A set host request on a B-role device starts Host Negotiation when the bus enters suspend.
// - The host request bit clears itself when negotiation completes and only acts in the B role.
// - As B device, the controller sets the session bit at session start and clears it at end.
// - Clearing the session bit while suspended makes the controller do a software disconnect.
// - Bit 4 of each FIFO size register selects single (0) or double (1) packet buffering.
// - A four-bit size code m gives a FIFO of 2^(m+3) bytes single or 2^(m+4) bytes double.
// - Bit 7 of device control reports the A (0) or B (1) role, valid during a session.
// - The VBUS code sits read-only in bits 4 to 3 of device control.
package otg_ctrl_pkg;

  // Byte addresses of the registers on APB.
  localparam logic [11:0] otg_device_control_addr    = 12'h000;
  localparam logic [11:0] tx_endpoint_fifo_size_addr = 12'h004;
  localparam logic [11:0] rx_endpoint_fifo_size_addr = 12'h008;
  localparam logic [11:0] fifo_bytes_addr            = 12'h00c;

  // Field positions in device control.
  localparam int session_bit  = 0;
  localparam int host_req_bit = 1;
  localparam int host_bit     = 2;
  localparam int vbus_lo_bit  = 3;
  localparam int b_role_bit   = 7;

  // Field positions in the FIFO size registers.
  localparam int double_buffer_bit = 4;
  localparam int size_msb          = 3;

  // Exponent offsets for the FIFO size.
  localparam logic [4:0] single_shift = 5'h03;
  localparam logic [4:0] double_shift = 5'h04;

  // Values after reset.
  localparam logic [7:0] fifo_size_reset = 8'h00;
  localparam logic       flag_reset      = 1'b0;

  // VBUS band codes.
  localparam logic [1:0] vbus_below_end  = 2'h0;
  localparam logic [1:0] vbus_above_end  = 2'h1;
  localparam logic [1:0] vbus_above_aval = 2'h2;
  localparam logic [1:0] vbus_above_vval = 2'h3;

  // Negotiation sequencer states.
  typedef enum logic [1:0] {neg_idle, neg_wait_suspend, neg_active} neg_state_e;

endpackage

// file: rtl/otg_role_and_fifo_sizing.sv
// OTG role, session control and endpoint FIFO sizing registers on APB.
// Assumes PHY and link status pins are asynchronous and are synchronised here.
// Assumes an APB master that follows every setup cycle with one access cycle.
// The link consumes the size, buffering and byte counts as registered levels.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module otg_role_and_fifo_sizing
  import otg_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator and link status from the PHY side.
  input  wire logic        session_end_above,
  input  wire logic        a_valid_above,
  input  wire logic        vbus_valid_above,
  input  wire logic        id_is_b,
  input  wire logic        link_host_active,
  input  wire logic        link_suspended,
  input  wire logic        link_session_active,
  input  wire logic        negotiation_done,
  // Controls toward the link.
  output logic             start_negotiation,
  output logic             session_enable,
  output logic             soft_disconnect,
  output logic             tx_double_buffer,
  output logic             rx_double_buffer,
  output logic      [3:0]  tx_size_code,
  output logic      [3:0]  rx_size_code,
  output logic      [19:0] tx_fifo_bytes,
  output logic      [19:0] rx_fifo_bytes
);

  // Size in bytes from a size code and the double buffer bit.
  // The largest case, code 15 with double buffering, is 2^19 bytes, so the
  // result is twenty bits wide; the exponent needs five bits for the same reason.
  function automatic logic [19:0] fifo_bytes(input logic [3:0] m, input logic dbl);
    logic [4:0] e;
    e = {1'b0, m} + (dbl ? double_shift : single_shift);
    fifo_bytes = 20'h00001 << e;
  endfunction

  // Synchroniser chain for the eight asynchronous status inputs.
  // Every status input crosses from the PHY or link domain. Two flops per bit
  // keep metastability out of the decode; only the second stage is read.
  // Bits are not kept coherent with each other, which is harmless here because
  // each one is a slow level and is decoded on its own.
  logic [7:0] sync1_reg, sync1_next;
  logic [7:0] sync2_reg, sync2_next;
  logic [7:0] raw_in;
  logic       s_end, s_aval, s_vval, s_b, s_host, s_susp, s_sess, s_done;

  assign raw_in = {negotiation_done, link_session_active, link_suspended, link_host_active,
                   id_is_b, vbus_valid_above, a_valid_above, session_end_above};
  assign {s_done, s_sess, s_susp, s_host, s_b, s_vval, s_aval, s_end} = sync2_reg;

  // Next values of the synchronisers; the first stage samples the pins and the
  // second stage samples the first.
  always_comb
  begin
    sync1_next = raw_in;
    sync2_next = sync1_reg;
  end

  // Register the synchronisers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Register map as seen by software, one aligned 32-bit word per register:
  //   device control   b7 B role, b6:5 zero, b4:3 VBUS band, b2 host role,
  //                    b1 host negotiation request, b0 session.
  //   tx FIFO size     b4 double buffer enable, b3:0 size code, b7:5 read zero.
  //   rx FIFO size     same layout as the transmit register.
  //   FIFO bytes       read-only transmit byte count in b19:0, other bits zero.
  // Any other address answers with an error; writes there change nothing and
  // reads return zero. Every transfer is answered in the cycle after setup, so
  // pready, prdata and pslverr are plain flip-flops with no wait-state logic.
  // Register and sequencer state. The session-seen flop holds the previous
  // synchronised session level for edge detection; it resets low, the idle
  // level of the link session input, so no false edge follows reset.
  logic [1:0]  vbus_reg, vbus_next;
  logic        host_reg, host_next;
  logic        b_reg, b_next;
  logic        hreq_reg, hreq_next;
  logic        sess_reg, sess_next;
  logic        sess_seen_reg, sess_seen_next;
  logic        disc_reg, disc_next;
  logic        neg_out_reg, neg_out_next;
  logic [4:0]  txsz_reg, txsz_next;
  logic [4:0]  rxsz_reg, rxsz_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ready_reg, ready_next;
  logic        err_reg, err_next;
  neg_state_e  neg_reg, neg_next;
  logic        wr, rd, setup;
  logic [7:0]  dev_ctrl_view;

  // Bus phases. A request is taken in its setup cycle only, so the access
  // cycle that follows can never start a second write.
  assign setup = psel && !penable;
  assign wr    = setup && pwrite;
  assign rd    = setup && !pwrite;

  // Readable view of device control; the two speed bits are outside this block
  // and read as zero.
  assign dev_ctrl_view = {b_reg, 2'b00, vbus_reg, host_reg, hreq_reg, sess_reg};

  // Next values of status, control and bus answer.
  always_comb
  begin
    vbus_next      = vbus_below_end;
    host_next      = s_host;
    b_next         = s_sess ? s_b : b_reg;
    hreq_next      = hreq_reg;
    sess_next      = sess_reg;
    sess_seen_next = s_sess;
    disc_next      = disc_reg;
    neg_next       = neg_reg;
    neg_out_next   = 1'b0;
    txsz_next      = txsz_reg;
    rxsz_next      = rxsz_reg;
    rdata_next     = 32'h00000000;
    ready_next     = 1'b0;
    err_next       = 1'b0;
    // Band code from the three comparators. The thresholds rise in order, so
    // the highest comparator that is above wins; a momentary disagreement while
    // VBUS ramps only shows an intermediate band for a cycle or two.
    if (s_vval)
      vbus_next = vbus_above_vval;
    else if (s_aval)
      vbus_next = vbus_above_aval;
    else if (s_end)
      vbus_next = vbus_above_end;
    // B role follows link session start and end. Only the edges of the
    // synchronised session level move the bit, so software may still write it
    // in between, for example to request a session by SRP.
    if (s_b && s_sess && !sess_seen_reg)
      sess_next = 1'b1;
    else if (s_b && !s_sess && sess_seen_reg)
      sess_next = 1'b0;
    // The disconnect request is a level; it falls once the session resumes or
    // the bus leaves suspend, and a fresh clear while suspended raises it again.
    if (s_sess || !s_susp)
      disc_next = 1'b0;
    // Register writes, taken in the setup cycle and answered in the next one.
    // A write to the byte count register is accepted and ignored.
    if (wr)
    begin
      case (paddr)
        otg_device_control_addr:
        begin
          hreq_next = pwdata[host_req_bit];
          sess_next = pwdata[session_bit];
          if (s_susp && sess_reg && !pwdata[session_bit])
            disc_next = 1'b1;
        end
        tx_endpoint_fifo_size_addr: txsz_next = pwdata[double_buffer_bit:0];
        rx_endpoint_fifo_size_addr: rxsz_next = pwdata[double_buffer_bit:0];
        fifo_bytes_addr: err_next = 1'b0;
        default: err_next = 1'b1;
      endcase
      ready_next = 1'b1;
    end
    // Register reads; the data comes from the registers as they stand in the
    // setup cycle.
    if (rd)
    begin
      case (paddr)
        otg_device_control_addr:    rdata_next = {24'h000000, dev_ctrl_view};
        tx_endpoint_fifo_size_addr: rdata_next = {27'h0000000, txsz_reg};
        rx_endpoint_fifo_size_addr: rdata_next = {27'h0000000, rxsz_reg};
        fifo_bytes_addr:
          rdata_next = {12'h000, fifo_bytes(txsz_reg[size_msb:0], txsz_reg[double_buffer_bit])};
        default: err_next = 1'b1;
      endcase
      ready_next = 1'b1;
    end
    // Host Negotiation sequencer, B role only. The request is watched until the
    // bus suspends; dropping the request or losing the B role before then
    // abandons it. Completion from the link clears the request, and that clear
    // comes after the register write so it wins over a write in the same cycle.
    case (neg_reg)
      neg_idle:
        if (hreq_reg && s_b)
          neg_next = neg_wait_suspend;
      neg_wait_suspend:
        if (!hreq_reg || !s_b)
          neg_next = neg_idle;
        else if (s_susp)
        begin
          neg_next     = neg_active;
          neg_out_next = 1'b1;
        end
      neg_active:
        if (s_done)
        begin
          neg_next  = neg_idle;
          hreq_next = 1'b0;
        end
      default: neg_next = neg_idle;
    endcase
  end

  // Register all state; reset returns every field to its documented zero.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vbus_reg      <= vbus_below_end;
      host_reg      <= flag_reset;
      b_reg         <= flag_reset;
      hreq_reg      <= flag_reset;
      sess_reg      <= flag_reset;
      sess_seen_reg <= flag_reset;
      disc_reg      <= flag_reset;
      neg_out_reg   <= flag_reset;
      txsz_reg      <= fifo_size_reset[4:0];
      rxsz_reg      <= fifo_size_reset[4:0];
      rdata_reg     <= 32'h00000000;
      ready_reg     <= 1'b0;
      err_reg       <= 1'b0;
      neg_reg       <= neg_idle;
    end
    else
    begin
      vbus_reg      <= vbus_next;
      host_reg      <= host_next;
      b_reg         <= b_next;
      hreq_reg      <= hreq_next;
      sess_reg      <= sess_next;
      sess_seen_reg <= sess_seen_next;
      disc_reg      <= disc_next;
      neg_out_reg   <= neg_out_next;
      txsz_reg      <= txsz_next;
      rxsz_reg      <= rxsz_next;
      rdata_reg     <= rdata_next;
      ready_reg     <= ready_next;
      err_reg       <= err_next;
      neg_reg       <= neg_next;
    end
  end

  // Byte counts toward the link, registered so the shifter stays off the output path.
  logic [19:0] txb_reg, txb_next;
  logic [19:0] rxb_reg, rxb_next;

  // Next byte counts follow the size registers; the link sees them one clock later.
  always_comb
  begin
    txb_next = fifo_bytes(txsz_reg[size_msb:0], txsz_reg[double_buffer_bit]);
    rxb_next = fifo_bytes(rxsz_reg[size_msb:0], rxsz_reg[double_buffer_bit]);
  end

  // Register the derived FIFO byte counts.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txb_reg <= 20'h00000;
      rxb_reg <= 20'h00000;
    end
    else
    begin
      txb_reg <= txb_next;
      rxb_reg <= rxb_next;
    end
  end

  // Outputs straight from flip-flops; the size fields are slices of the size
  // registers, so they change in the same cycle that the write lands.
  assign prdata            = rdata_reg;
  assign pready            = ready_reg;
  assign pslverr           = err_reg;
  assign start_negotiation = neg_out_reg;
  assign session_enable    = sess_reg;
  assign soft_disconnect   = disc_reg;
  assign tx_double_buffer  = txsz_reg[double_buffer_bit];
  assign rx_double_buffer  = rxsz_reg[double_buffer_bit];
  assign tx_size_code      = txsz_reg[size_msb:0];
  assign rx_size_code      = rxsz_reg[size_msb:0];
  assign tx_fifo_bytes     = txb_reg;
  assign rx_fifo_bytes     = rxb_reg;

endmodule

// file: bench/otg_role_properties.sv
// Checker for the OTG role and FIFO sizing block, seeing only its ports.
// Assumes one clock domain, clk with synchronous active-high rst.
`timescale 1ns/100ps
module otg_role_properties
  import otg_ctrl_pkg::*;
(
  // Clock, reset and APB.
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Link controls and FIFO sizes.
  input wire logic        start_negotiation, session_enable, soft_disconnect,
  input wire logic        tx_double_buffer, rx_double_buffer,
  input wire logic [3:0]  tx_size_code, rx_size_code,
  input wire logic [19:0] tx_fifo_bytes, rx_fifo_bytes
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Every setup cycle is answered in the following cycle.
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("Setup not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready held too long");
  error_reply_a: assert property (pslverr |-> pready)
    else $error("Error reply without ready");
  nego_pulse_a: assert property (start_negotiation |=> !start_negotiation)
    else $error("Negotiation start not a pulse");
  // Byte size follows the size code and buffering one cycle later.
  tx_bytes_a: assert property (!$past(rst) |-> tx_fifo_bytes ==
    20'h1 << ({1'b0, $past(tx_size_code)} + ($past(tx_double_buffer) ? 5'h04 : 5'h03)))
    else $error("Transmit byte size wrong");
  rx_bytes_a: assert property (!$past(rst) |-> rx_fifo_bytes ==
    20'h1 << ({1'b0, $past(rx_size_code)} + ($past(rx_double_buffer) ? 5'h04 : 5'h03)))
    else $error("Receive byte size wrong");
  size_zeros_a: assert property (pready && !pwrite &&
    (paddr == tx_endpoint_fifo_size_addr || paddr == rx_endpoint_fifo_size_addr)
    |-> prdata[31:5] == 27'h0) else $error("Size register upper bits not zero");
  disc_sess_a: assert property ($rose(soft_disconnect) |-> !session_enable)
    else $error("Disconnect while session set");
endmodule

bind otg_role_and_fifo_sizing otg_role_properties u_props (.*);

// file: bench/usb_far_side.sv
// Behavioural model of the cable partner and PHY comparators.
// Assumes the bench picks the VBUS band; completion answers a start pulse.
`timescale 1ns/100ps
module usb_far_side (
  // Clock, reset and requests.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start_negotiation,
  input  wire logic [1:0] band,
  // Comparators and completion.
  output logic            session_end_above,
  output logic            a_valid_above,
  output logic            vbus_valid_above,
  output logic            negotiation_done
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;

  // Thresholds rise in order, so each band sets a prefix of comparators.
  assign session_end_above = band >= 2'h1;
  assign a_valid_above     = band >= 2'h2;
  assign vbus_valid_above  = band == 2'h3;

  // Completion is reported some cycles after start, held four cycles.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (start_negotiation)
      cnt_next = 3'h7;
    else if (cnt_reg != 3'h0)
      cnt_next = cnt_reg - 3'h1;
  end
  always_ff @(posedge clk)
    cnt_reg <= rst ? 3'h0 : cnt_next;
  assign negotiation_done = cnt_reg != 3'h0 && cnt_reg < 3'h5;
endmodule

// file: bench/test_otg_role_and_fifo_sizing.sv
// Self-checking bench for the OTG role and FIFO sizing block.
// Assumes the far-side model and the property checker are compiled alongside.
`timescale 1ns/100ps
module test_otg_role_and_fifo_sizing
  import otg_ctrl_pkg::*;
;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] band = 0;
  logic id_is_b = 0, link_host_active = 0, link_suspended = 0, sess = 0, er;
  logic se, av, vv, done, start, sess_en, disc, txd, rxd;
  logic [3:0] txc, rxc;
  logic [19:0] txb, rxb;
  int errors = 0, compares = 0;

  otg_role_and_fifo_sizing u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .session_end_above(se), .a_valid_above(av),
    .vbus_valid_above(vv), .id_is_b, .link_host_active, .link_suspended,
    .link_session_active(sess), .negotiation_done(done), .start_negotiation(start),
    .session_enable(sess_en), .soft_disconnect(disc), .tx_double_buffer(txd),
    .rx_double_buffer(rxd), .tx_size_code(txc), .rx_size_code(rxc),
    .tx_fifo_bytes(txb), .rx_fifo_bytes(rxb));
  usb_far_side u_far (.clk, .rst, .start_negotiation(start), .band,
    .session_end_above(se), .a_valid_above(av), .vbus_valid_above(vv),
    .negotiation_done(done));

  initial forever #12.5 clk = ~clk;

  task automatic conclude();
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer, entered and left just after a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (!pready && n < 9);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!pready) begin errors++; conclude(); end
    @(posedge clk);
  endtask

  // Bounded wait for a design output to go high.
  task automatic await(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 30) begin @(posedge clk); n++; end
    if (s !== 1'b1) begin errors++; conclude(); end
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  // Each VBUS band, then writes to read-only device control bits.
  task automatic t_vbus();
    for (int i = 0; i < 4; i++)
    begin
      band <= 2'(i);
      settle();
      apb(0, otg_device_control_addr, 0);
      `CHK("vbus", 2'(i), rd[4:3])
    end
    apb(1, otg_device_control_addr, 32'h9c);
    apb(0, otg_device_control_addr, 0);
    `CHK("dev_ctrl", 32'h18, rd)
    link_host_active <= 1;
    settle();
    apb(0, otg_device_control_addr, 0);
    `CHK("host", 1'b1, rd[2])
    link_host_active <= 0;
  endtask

  // Size codes at both ends, both buffering modes, both directions.
  task automatic t_fifo();
    logic [11:0] a;
    logic [3:0] m;
    for (int k = 0; k < 8; k++)
    begin
      a = k[2] ? rx_endpoint_fifo_size_addr : tx_endpoint_fifo_size_addr;
      m = k[0] ? 4'hf : 4'h0;
      apb(1, a, {24'h0, 3'h7, k[1], m});
      apb(0, a, 0);
      `CHK("size", {27'h0, k[1], m}, rd)
      `CHK("bytes", 20'h1 << (m + 3 + k[1]), k[2] ? rxb : txb)
    end
    apb(0, fifo_bytes_addr, 0);
    `CHK("bytes_reg", 32'h00080000, rd)
  endtask

  // Negotiation waits for suspend and clears the request on completion.
  task automatic t_hnp();
    id_is_b <= 1;
    settle();
    apb(1, otg_device_control_addr, 32'h2);
    repeat (8) @(posedge clk) `CHK("early", 1'b0, start)
    link_suspended <= 1;
    await(start);
    repeat (12) @(posedge clk);
    apb(0, otg_device_control_addr, 0);
    `CHK("hreq", 1'b0, rd[1])
    link_suspended <= 0;
    sess <= 1;
    settle();
    apb(0, otg_device_control_addr, 0);
    `CHK("bsess", 2'h3, {rd[7], rd[0]})
    sess <= 0;
    settle();
    apb(0, otg_device_control_addr, 0);
    `CHK("bend", 1'b0, rd[0])
    id_is_b <= 0;
  endtask

  // A-role session set by software, then cleared during suspend.
  task automatic t_disc();
    settle();
    apb(1, otg_device_control_addr, 32'h1);
    `CHK("sess", 1'b1, sess_en)
    link_suspended <= 1;
    settle();
    apb(1, otg_device_control_addr, 32'h0);
    await(disc);
    `CHK("off", 1'b0, sess_en)
    link_suspended <= 0;
    apb(0, 12'h010, 0);
    `CHK("unmapped", 33'h100000000, {er, rd})
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, tx_endpoint_fifo_size_addr, 0);
    `CHK("reset", 32'h0, rd)
    t_vbus();
    t_fifo();
    t_hnp();
    t_disc();
    conclude();
  end
endmodule
